/* File: pkg/afb_pkg.sv */
`default_nettype none
package afb_pkg;

  // widths of the flash bus, of the software port and of the timer count
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam int CNT_W = 12;
  typedef logic [CNT_W-1:0] afb_cnt_t;

  // clock and synchroniser depth
  localparam int CLK_NS = 10;
  localparam int SYNC_STAGES = 2;

  // bus timing in ns, as printed
  localparam int T_AVQV_NS = 100;   // address to data
  localparam int T_ELQV_NS = 100;   // chip enable to data
  localparam int T_GHQZ_NS = 20;    // output enable high to bus released
  localparam int T_PHQV_NS = 600;   // reset high to valid data
  localparam int T_PHWL_NS = 1000;  // reset high to write strobe
  localparam int T_PLPH_NS = 100;   // reset pulse low
  localparam int T_PLR1_NS = 30000; // reset abort of a running operation
  localparam int T_ELWL_NS = 10;
  localparam int T_WLWH_NS = 50;
  localparam int T_WHEH_NS = 10;
  localparam int T_WHWL_NS = 30;
  localparam int T_WLEL_NS = 0;
  localparam int T_ELEH_NS = 65;
  localparam int T_EHWH_NS = 0;
  localparam int T_EHEL_NS = 25;
  localparam int T_WHR0_NS = 100;   // strobe high to ready bit low
  localparam int T_SHWH_NS = 100;   // protect and supply setup

  // least time to whole cycles, never below one
  function automatic int min_cyc(int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam afb_cnt_t C_ACC = CNT_W'(min_cyc(T_AVQV_NS > T_ELQV_NS ? T_AVQV_NS : T_ELQV_NS)
                                      + SYNC_STAGES);
  localparam afb_cnt_t C_GHQZ = CNT_W'(min_cyc(T_GHQZ_NS));
  localparam afb_cnt_t C_REC = CNT_W'(min_cyc(T_PHWL_NS > T_PHQV_NS ? T_PHWL_NS : T_PHQV_NS));
  localparam afb_cnt_t C_PLPH = CNT_W'(min_cyc(T_PLPH_NS));
  localparam afb_cnt_t C_PLR1 = CNT_W'(min_cyc(T_PLR1_NS));
  localparam afb_cnt_t C_ELWL = CNT_W'(min_cyc(T_ELWL_NS));
  localparam afb_cnt_t C_WLWH = CNT_W'(min_cyc(T_WLWH_NS));
  localparam afb_cnt_t C_WHEH = CNT_W'(min_cyc(T_WHEH_NS));
  localparam afb_cnt_t C_WHWL = CNT_W'(min_cyc(T_WHWL_NS));
  localparam afb_cnt_t C_WLEL = CNT_W'(min_cyc(T_WLEL_NS));
  localparam afb_cnt_t C_ELEH = CNT_W'(min_cyc(T_ELEH_NS));
  localparam afb_cnt_t C_EHWH = CNT_W'(min_cyc(T_EHWH_NS));
  localparam afb_cnt_t C_EHEL = CNT_W'(min_cyc(T_EHEL_NS));
  localparam afb_cnt_t C_WHR0 = CNT_W'(min_cyc(T_WHR0_NS));
  localparam afb_cnt_t C_SHWH = CNT_W'(min_cyc(T_SHWH_NS));

  // register offsets (byte addresses)
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_ADDR = 8'h04;
  localparam logic [REG_AW-1:0] REG_WDATA = 8'h08;
  localparam logic [REG_AW-1:0] REG_RDATA = 8'h0c;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h10;

  // control register fields
  localparam int CTRL_GO_WRITE = 0;
  localparam int CTRL_GO_READ = 1;
  localparam int CTRL_GO_POLL = 2;
  localparam int CTRL_GO_RESET = 3;
  localparam int CTRL_CE_TIMED = 8;
  localparam int CTRL_SUPPLY = 9;
  localparam int CTRL_WP_RELEASE = 10;
  localparam int CTRL_STARTS_OP = 11;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_PENDING = 1;
  localparam int STAT_READY = 2;
  localparam int STAT_ERROR = 3;
  localparam int STAT_REJECTED = 4;

  // device status word bits
  localparam int SR_READY = 7;
  localparam logic [DATA_W-1:0] SR_ERR_MASK = 16'h003a;

  typedef enum logic [3:0] {
    ST_RST_LOW,
    ST_RST_REC,
    ST_IDLE,
    ST_W_SETUP,
    ST_W_STROBE,
    ST_W_HOLD,
    ST_W_GAP,
    ST_P_WAIT,
    ST_R_ACC,
    ST_R_REL
  } afb_state_e;

endpackage
`default_nettype wire

/* File: core/afb_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module afb_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire afb_pkg::afb_cnt_t value,
  // status
  output logic done
);

  afb_pkg::afb_cnt_t cnt_r;
  afb_pkg::afb_cnt_t cnt_nxt;

  // count down to zero and rest there; a load restarts it
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = value;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - afb_pkg::afb_cnt_t'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // done looks at the count only, so the caller's load never loops back into it
  assign done = (cnt_r == '0);

endmodule // afb_timer
`default_nettype wire

/* File: core/afb_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module afb_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software register port
  input wire logic [afb_pkg::REG_AW-1:0] reg_addr,
  input wire logic [afb_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [afb_pkg::REG_DW-1:0] reg_rdata,
  // flash address and data
  output logic [afb_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [afb_pkg::DATA_W-1:0] flash_dq_in,
  output logic [afb_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  // flash strobes and levels
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic reset_powerdown_n,
  output logic flash_wp_n,
  output logic program_supply_en
);

  // state and its next values
  afb_pkg::afb_state_e state_r, state_nxt;
  logic [afb_pkg::ADDR_W-1:0] addr_cfg_r, addr_cfg_nxt;
  logic [afb_pkg::DATA_W-1:0] wdata_cfg_r, wdata_cfg_nxt;
  logic [afb_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [afb_pkg::REG_DW-1:0] reg_rdata_r, reg_rdata_nxt;
  logic ce_timed_r, ce_timed_nxt;
  logic supply_cfg_r, supply_cfg_nxt;
  logic wp_rel_r, wp_rel_nxt;
  logic starts_op_r, starts_op_nxt;
  logic poll_r, poll_nxt;
  logic pending_r, pending_nxt;
  logic ready_r, ready_nxt;
  logic error_r, error_nxt;
  logic rejected_r, rejected_nxt;
  logic [afb_pkg::ADDR_W-1:0] pin_addr_r, pin_addr_nxt;
  logic [afb_pkg::DATA_W-1:0] pin_dq_r, pin_dq_nxt;
  logic dq_oe_r, dq_oe_nxt;
  logic ce_n_r, ce_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic we_n_r, we_n_nxt;
  logic rp_n_r, rp_n_nxt;
  logic wp_n_r, wp_n_nxt;
  logic supply_r, supply_nxt;
  logic [3:0] settle_r, settle_nxt;
  logic boot_r, boot_nxt;

  // data pin synchroniser: stage one feeds only stage two
  logic [afb_pkg::DATA_W-1:0] dq_s1_r, dq_s2_r;

  // timer hookup
  logic tmr_load;
  afb_pkg::afb_cnt_t tmr_val;
  logic tmr_done;

  // decoded commands
  logic ctrl_wr, go_write, go_read, go_poll, go_reset, go_any;

  afb_timer u_timer (
    .clk(clk),
    .rst(rst),
    .load(tmr_load),
    .value(tmr_val),
    .done(tmr_done)
  );

  assign ctrl_wr = reg_wr && (reg_addr == afb_pkg::REG_CTRL);
  assign go_write = ctrl_wr && reg_wdata[afb_pkg::CTRL_GO_WRITE];
  assign go_read = ctrl_wr && reg_wdata[afb_pkg::CTRL_GO_READ];
  assign go_poll = ctrl_wr && reg_wdata[afb_pkg::CTRL_GO_POLL];
  assign go_reset = ctrl_wr && reg_wdata[afb_pkg::CTRL_GO_RESET];
  assign go_any = go_write || go_read || go_poll || go_reset;

  // two flops before anything looks at the data pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // register port, command sequencer and pin drive
  always_comb begin
    state_nxt = state_r;
    addr_cfg_nxt = addr_cfg_r;
    wdata_cfg_nxt = wdata_cfg_r;
    rdata_nxt = rdata_r;
    reg_rdata_nxt = '0;
    ce_timed_nxt = ce_timed_r;
    supply_cfg_nxt = supply_cfg_r;
    wp_rel_nxt = wp_rel_r;
    starts_op_nxt = starts_op_r;
    poll_nxt = poll_r;
    pending_nxt = pending_r;
    ready_nxt = ready_r;
    error_nxt = error_r;
    rejected_nxt = rejected_r;
    pin_addr_nxt = pin_addr_r;
    pin_dq_nxt = pin_dq_r;
    dq_oe_nxt = dq_oe_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    rp_n_nxt = rp_n_r;
    settle_nxt = settle_r;
    boot_nxt = boot_r;
    tmr_load = 1'b0;
    tmr_val = '0;

    // software writes to configuration
    if (ctrl_wr) begin
      ce_timed_nxt = reg_wdata[afb_pkg::CTRL_CE_TIMED];
      supply_cfg_nxt = reg_wdata[afb_pkg::CTRL_SUPPLY];
      wp_rel_nxt = reg_wdata[afb_pkg::CTRL_WP_RELEASE];
    end else if (reg_wr && reg_addr == afb_pkg::REG_ADDR) begin
      addr_cfg_nxt = reg_wdata[afb_pkg::ADDR_W-1:0];
    end else if (reg_wr && reg_addr == afb_pkg::REG_WDATA) begin
      wdata_cfg_nxt = reg_wdata[afb_pkg::DATA_W-1:0];
    end else if (reg_wr && reg_addr == afb_pkg::REG_STATUS &&
                 reg_wdata[afb_pkg::STAT_REJECTED]) begin
      rejected_nxt = 1'b0;
    end

    // read data lands one cycle after the strobe; unmapped reads zero
    if (reg_rd) begin
      if (reg_addr == afb_pkg::REG_CTRL) begin
        reg_rdata_nxt[afb_pkg::CTRL_CE_TIMED] = ce_timed_r;
        reg_rdata_nxt[afb_pkg::CTRL_SUPPLY] = supply_cfg_r;
        reg_rdata_nxt[afb_pkg::CTRL_WP_RELEASE] = wp_rel_r;
      end else if (reg_addr == afb_pkg::REG_ADDR) begin
        reg_rdata_nxt[afb_pkg::ADDR_W-1:0] = addr_cfg_r;
      end else if (reg_addr == afb_pkg::REG_WDATA) begin
        reg_rdata_nxt[afb_pkg::DATA_W-1:0] = wdata_cfg_r;
      end else if (reg_addr == afb_pkg::REG_RDATA) begin
        reg_rdata_nxt[afb_pkg::DATA_W-1:0] = rdata_r;
      end else if (reg_addr == afb_pkg::REG_STATUS) begin
        reg_rdata_nxt[afb_pkg::STAT_BUSY] = (state_r != afb_pkg::ST_IDLE);
        reg_rdata_nxt[afb_pkg::STAT_PENDING] = pending_r;
        reg_rdata_nxt[afb_pkg::STAT_READY] = ready_r;
        reg_rdata_nxt[afb_pkg::STAT_ERROR] = error_r;
        reg_rdata_nxt[afb_pkg::STAT_REJECTED] = rejected_r;
      end
    end

    // a command outside idle is dropped and flagged; set beats clear
    if (go_any && state_r != afb_pkg::ST_IDLE) begin
      rejected_nxt = 1'b1;
    end

    case (state_r)
      afb_pkg::ST_RST_LOW: begin
        if (boot_r) begin
          // the timer reads zero after rst, so arm the pulse time first
          boot_nxt = 1'b0;
          tmr_load = 1'b1;
          tmr_val = afb_pkg::C_PLPH;
        end else if (tmr_done) begin
          rp_n_nxt = 1'b1;
          tmr_load = 1'b1;
          tmr_val = afb_pkg::C_REC;
          state_nxt = afb_pkg::ST_RST_REC;
        end
      end
      afb_pkg::ST_RST_REC: begin
        if (tmr_done) begin
          pending_nxt = 1'b0; // any running operation was aborted
          state_nxt = afb_pkg::ST_IDLE;
        end
      end
      afb_pkg::ST_IDLE: begin
        if (go_reset) begin
          rp_n_nxt = 1'b0;
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          dq_oe_nxt = 1'b0;
          tmr_load = 1'b1;
          // long hold lets a running operation abort
          tmr_val = pending_r ? afb_pkg::C_PLR1 : afb_pkg::C_PLPH;
          state_nxt = afb_pkg::ST_RST_LOW;
        end else if (go_write && pending_r) begin
          rejected_nxt = 1'b1; // no new write while an operation runs; reads, polls and reset still start
        end else if (go_write) begin
          // address and data go out with the first strobe edge
          pin_addr_nxt = addr_cfg_r;
          pin_dq_nxt = wdata_cfg_r;
          dq_oe_nxt = 1'b1;
          starts_op_nxt = reg_wdata[afb_pkg::CTRL_STARTS_OP];
          tmr_load = 1'b1;
          if (reg_wdata[afb_pkg::CTRL_CE_TIMED]) begin
            we_n_nxt = 1'b0;
            tmr_val = afb_pkg::C_WLEL;
          end else begin
            ce_n_nxt = 1'b0;
            tmr_val = afb_pkg::C_ELWL;
          end
          state_nxt = afb_pkg::ST_W_SETUP;
        end else if (go_read || go_poll) begin
          // both strobes together keep access at its shortest
          pin_addr_nxt = addr_cfg_r;
          ce_n_nxt = 1'b0;
          oe_n_nxt = 1'b0;
          poll_nxt = go_poll;
          tmr_load = 1'b1;
          tmr_val = afb_pkg::C_ACC;
          state_nxt = afb_pkg::ST_R_ACC;
        end
      end
      afb_pkg::ST_W_SETUP: begin
        if (tmr_done && settle_r == 4'h0) begin
          tmr_load = 1'b1;
          if (ce_timed_r) begin
            ce_n_nxt = 1'b0;
            tmr_val = afb_pkg::C_ELEH;
          end else begin
            we_n_nxt = 1'b0;
            tmr_val = afb_pkg::C_WLWH;
          end
          state_nxt = afb_pkg::ST_W_STROBE;
        end
      end
      afb_pkg::ST_W_STROBE: begin
        // data stood since setup, well over 50 ns before this edge
        if (tmr_done) begin
          tmr_load = 1'b1;
          if (ce_timed_r) begin
            ce_n_nxt = 1'b1;
            tmr_val = afb_pkg::C_EHWH;
          end else begin
            we_n_nxt = 1'b1;
            tmr_val = afb_pkg::C_WHEH;
          end
          state_nxt = afb_pkg::ST_W_HOLD;
        end
      end
      afb_pkg::ST_W_HOLD: begin
        if (tmr_done) begin
          ce_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          dq_oe_nxt = 1'b0;
          tmr_load = 1'b1;
          tmr_val = ce_timed_r ? afb_pkg::C_EHEL : afb_pkg::C_WHWL;
          state_nxt = afb_pkg::ST_W_GAP;
        end
      end
      afb_pkg::ST_W_GAP: begin
        if (tmr_done) begin
          if (starts_op_r) begin
            // ready bit is stale until it has had time to drop
            pending_nxt = 1'b1;
            poll_nxt = 1'b1;
            tmr_load = 1'b1;
            tmr_val = afb_pkg::C_WHR0;
            state_nxt = afb_pkg::ST_P_WAIT;
          end else begin
            state_nxt = afb_pkg::ST_IDLE; // a read may start at once
          end
        end
      end
      afb_pkg::ST_P_WAIT: begin
        if (tmr_done) begin
          ce_n_nxt = 1'b0;
          oe_n_nxt = 1'b0;
          tmr_load = 1'b1;
          tmr_val = afb_pkg::C_ACC;
          state_nxt = afb_pkg::ST_R_ACC;
        end
      end
      afb_pkg::ST_R_ACC: begin
        if (tmr_done) begin
          rdata_nxt = dq_s2_r;
          if (poll_r) begin
            ready_nxt = dq_s2_r[afb_pkg::SR_READY];
            error_nxt = |(dq_s2_r & afb_pkg::SR_ERR_MASK);
          end
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          tmr_load = 1'b1;
          tmr_val = afb_pkg::C_GHQZ;
          state_nxt = afb_pkg::ST_R_REL;
        end
      end
      afb_pkg::ST_R_REL: begin
        if (tmr_done) begin
          if (poll_r && !ready_r) begin
            // keep polling until the device reports ready
            ce_n_nxt = 1'b0;
            oe_n_nxt = 1'b0;
            tmr_load = 1'b1;
            tmr_val = afb_pkg::C_ACC;
            state_nxt = afb_pkg::ST_R_ACC;
          end else begin
            if (poll_r) begin
              pending_nxt = 1'b0;
            end
            poll_nxt = 1'b0;
            state_nxt = afb_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = afb_pkg::ST_IDLE;
      end
    endcase

    wp_n_nxt = wp_rel_nxt;
    // supply stays up while an operation is outstanding
    supply_nxt = supply_cfg_nxt || pending_nxt;

    // protect and supply must settle before a strobe ends; done last to see this cycle's levels
    if (wp_n_nxt != wp_n_r || supply_nxt != supply_r) begin
      settle_nxt = 4'(afb_pkg::C_SHWH);
    end else if (settle_r != 4'h0) begin
      settle_nxt = settle_r - 4'h1;
    end
  end

  // power-up holds reset low for the pulse time after rst drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= afb_pkg::ST_RST_LOW;
      addr_cfg_r <= '0;
      wdata_cfg_r <= '0;
      rdata_r <= '0;
      reg_rdata_r <= '0;
      ce_timed_r <= 1'b0;
      supply_cfg_r <= 1'b0;
      wp_rel_r <= 1'b0;
      starts_op_r <= 1'b0;
      poll_r <= 1'b0;
      pending_r <= 1'b0;
      ready_r <= 1'b0;
      error_r <= 1'b0;
      rejected_r <= 1'b0;
      pin_addr_r <= '0;
      pin_dq_r <= '0;
      dq_oe_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      rp_n_r <= 1'b0;
      wp_n_r <= 1'b0;
      supply_r <= 1'b0;
      settle_r <= 4'h0;
      boot_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      addr_cfg_r <= addr_cfg_nxt;
      wdata_cfg_r <= wdata_cfg_nxt;
      rdata_r <= rdata_nxt;
      reg_rdata_r <= reg_rdata_nxt;
      ce_timed_r <= ce_timed_nxt;
      supply_cfg_r <= supply_cfg_nxt;
      wp_rel_r <= wp_rel_nxt;
      starts_op_r <= starts_op_nxt;
      poll_r <= poll_nxt;
      pending_r <= pending_nxt;
      ready_r <= ready_nxt;
      error_r <= error_nxt;
      rejected_r <= rejected_nxt;
      pin_addr_r <= pin_addr_nxt;
      pin_dq_r <= pin_dq_nxt;
      dq_oe_r <= dq_oe_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      rp_n_r <= rp_n_nxt;
      wp_n_r <= wp_n_nxt;
      supply_r <= supply_nxt;
      settle_r <= settle_nxt;
      boot_r <= boot_nxt;
    end
  end

  // every pin comes straight from a flop, so no glitches reach the flash
  assign reg_rdata = reg_rdata_r;
  assign flash_addr = pin_addr_r;
  assign flash_dq_out = pin_dq_r;
  assign flash_dq_oe = dq_oe_r;
  assign flash_ce_n = ce_n_r;
  assign flash_oe_n = oe_n_r;
  assign flash_we_n = we_n_r;
  assign reset_powerdown_n = rp_n_r;
  assign flash_wp_n = wp_n_r;
  assign program_supply_en = supply_r;

endmodule // afb_ctrl
`default_nettype wire

/* File: core/afb_note_end.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: test/afb_ctrl_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module afb_ctrl_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // flash pins
  input wire logic [afb_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [afb_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic reset_powerdown_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] rec_r;
  logic [7:0] rec_nxt;
  // cycles since reset pin release, saturating so a long idle never wraps
  always_comb begin
    rec_nxt = rec_r;
    if (!reset_powerdown_n) rec_nxt = 8'h00;
    else if (rec_r != 8'hff) rec_nxt = rec_r + 8'h01;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rec_r <= 8'h00;
    else rec_r <= rec_nxt;
  end
  rec_write_a: assert property (!flash_we_n |-> rec_r >= 8'h64)
    else $error("write strobe too soon after reset release");
  ce_setup_a: assert property ($fell(flash_we_n) && !flash_ce_n |-> !$past(flash_ce_n))
    else $error("chip enable not set up before write strobe");
  ce_hold_a: assert property ($rose(flash_we_n) && !$past(flash_ce_n) |-> !flash_ce_n)
    else $error("chip enable released with write strobe");
  we_width_a: assert property ($fell(flash_we_n) && !flash_ce_n |-> !flash_we_n [*5])
    else $error("write strobe pulse too short");
  we_gap_a: assert property ($rose(flash_we_n) |-> flash_we_n [*3])
    else $error("write strobe high time too short");
  we_setup_a: assert property ($rose(flash_we_n) && !flash_ce_n |->
    $past(flash_addr, 5) == flash_addr && $past(flash_dq_out, 5) == flash_dq_out
    && $past(flash_dq_oe, 5))
    else $error("address or data not stable before strobe rise");
  ce_width_a: assert property ($fell(flash_ce_n) && !flash_we_n |-> !flash_ce_n [*7])
    else $error("chip enable write pulse too short");
  ce_setup_data_a: assert property ($rose(flash_ce_n) && !flash_we_n |->
    $past(flash_addr, 7) == flash_addr && $past(flash_dq_out, 7) == flash_dq_out)
    else $error("address or data not stable before chip enable rise");
  bus_release_a: assert property ($rose(flash_oe_n) |-> !flash_dq_oe [*2])
    else $error("data driven before device released the bus");
  read_pair_a: assert property ($fell(flash_oe_n) |-> !flash_ce_n && flash_we_n && !flash_dq_oe)
    else $error("read started without chip enable or with bus driven");
endmodule // afb_ctrl_monitor
bind afb_ctrl afb_ctrl_monitor afb_ctrl_monitor_i (.clk(clk), .rst(rst), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .reset_powerdown_n(reset_powerdown_n));
`default_nettype wire

/* File: test/afb_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
module afb_flash_model #(
  parameter int T_ACC = 100,
  parameter int T_OP = 2000
) (
  // pins from the controller
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_drv,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rp_n,
  // data the device puts on the lines
  output logic [15:0] dq_q
);
  logic pce = 1'b1, pwe = 1'b1, poe = 1'b1, ready = 1'b1, err = 1'b0, arr = 1'b1;
  logic [19:0] pa = '0;
  logic [15:0] word;
  realtime t_chg = 0, t_rp = 0, t_end = 0;
  initial dq_q = '0;
  // one step per ns; pins are asynchronous, so edges are found by comparison
  always #1 begin
    word = arr ? (addr[15:0] ^ 16'h5a5a) : {8'h00, ready, 2'b00, err, 4'h0};
    if (addr != pa || ce_n != pce || oe_n != poe) t_chg = $realtime;
    if (!rp_n) begin // reset aborts a running operation
      ready = 1'b1;
      arr = 1'b1;
      t_rp = $realtime;
    end else if ((we_n && !pwe && !ce_n) || (ce_n && !pce && !we_n)) begin // first rise ends it
      arr = (dq_drv == 16'h00ff);
      if (dq_drv[15:1] == 15'h0068) begin // ready drops at once
        ready = 1'b0;
        err = dq_drv[0];
        t_end = $realtime + T_OP;
      end
    end else if (!ready && $realtime >= t_end) ready = 1'b1;
    // valid only after access and recovery, else ever-changing garbage
    if (!ce_n && !oe_n && $realtime - t_chg >= T_ACC && $realtime - t_rp >= 600) dq_q = word;
    else dq_q = ~dq_q;
    pce = ce_n;
    pwe = we_n;
    poe = oe_n;
    pa = addr;
  end
endmodule // afb_flash_model
`default_nettype wire

/* File: test/afb_ctrl_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module afb_ctrl_tb_top;
  logic clk, rst, reg_wr, reg_rd, dq_oe, ce_n, oe_n, we_n, rp_n, wp_n, sup;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [19:0] flash_addr;
  logic [15:0] dq_out, dq_q, dq_line;
  int err_count = 0, compares = 0;
  // controller owns the lines while enabled, otherwise the device does
  assign dq_line = dq_oe ? dq_out : dq_q;
  afb_ctrl afb_ctrl_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
    .flash_dq_in(dq_line), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .reset_powerdown_n(rp_n), .flash_wp_n(wp_n),
    .program_supply_en(sup));
  afb_flash_model #(.T_ACC(95)) afb_flash_model_i (.addr(flash_addr), .dq_drv(dq_line),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .dq_q(dq_q));
  task automatic complete_run;
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge clk);
  endtask
  // poll busy with a bound so a stuck sequence is reported, not hung on
  task automatic wait_idle;
    int n;
    n = 0;
    rd(8'h10, d);
    while (d[0] !== 1'b0 && n < 3000) begin
      rd(8'h10, d);
      n++;
    end
    check(d[0], 1'b0);
  endtask
  task automatic t_reset;
    repeat (8) @(posedge clk);
    check(rp_n, 1'b0);
    rd(8'h10, d);
    check(d[0], 1'b1);
    wr(8'h00, 32'h2);
    rd(8'h10, d);
    check(d[4], 1'b1);
    wr(8'h10, 32'h10);
    rd(8'h10, d);
    check(d[4], 1'b0);
    check(we_n, 1'b1);
    wait_idle;
  endtask
  task automatic t_map;
    wr(8'h00, 32'h600);
    rd(8'h00, d);
    check(d, 32'h600);
    check({wp_n, sup}, 2'b11);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, d);
    check(d, 32'h000fffff);
    rd(8'h14, d);
    check(d, 32'h0);
  endtask
  task automatic t_read(input logic [19:0] a);
    wr(8'h04, {12'h0, a});
    wr(8'h00, 32'h602);
    wait_idle;
    rd(8'h0c, d);
    check(d, {16'h0, a[15:0] ^ 16'h5a5a});
  endtask
  task automatic t_write(input logic ce_t, input logic e);
    logic [31:0] ctl;
    ctl = {23'h0, ce_t, 8'h0} | 32'h600;
    wr(8'h08, 32'h40);
    wr(8'h00, ctl | 32'h1);
    wait_idle; // setup write first
    wr(8'h08, {31'h68, e});
    wr(8'h00, ctl | 32'h801);
    // past strobe and gap, into the wait for the ready bit to drop, with the operation still running
    repeat (20) @(posedge clk);
    wr(8'h00, ctl & ~32'h200);
    check(sup, 1'b1);
    wait_idle;
    rd(8'h10, d);
    check(d[4:0], {1'b0, e, 3'b100});
    check(sup, 1'b0);
    wr(8'h08, 32'hff);
    wr(8'h00, ctl | 32'h1);
    wait_idle;
    t_read(20'h0abcd);
  endtask
  // status poll on demand, then a reset command from idle
  task automatic t_cmds;
    wr(8'h08, 32'h70);
    wr(8'h00, 32'h601);
    wait_idle;
    wr(8'h00, 32'h604);
    wait_idle;
    rd(8'h10, d);
    check(d[3:2], 2'b11);
    rd(8'h0c, d);
    check(d, 32'h90);
    wr(8'h00, 32'h608);
    check(rp_n, 1'b0);
    wait_idle;
    check(rp_n, 1'b1);
    t_read(20'h00f0f);
  endtask
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cut a hang well beyond the expected run
  initial begin
    #300000;
    err_count++;
    complete_run;
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_map;
    t_read(20'h12345);
    t_write(1'b0, 1'b0);
    t_write(1'b1, 1'b1);
    t_cmds;
    complete_run;
  end
endmodule // afb_ctrl_tb_top
`default_nettype wire
